// File: serial_port_uart_baudgen.sv
`timescale 1ns/1ps
// Overview of operation
// - Data write sends, data read gives received
// - Full duplex, one byte held while receiving
// - Mode bits pick frame and rate
// - Fixed 9-bit rate is clock/64 or /32
// - Receiver ignores line unless enabled
// - 9-bit modes send software ninth bit
// - 9-bit modes store received ninth bit
// - 8-bit mode stores stop bit as ninth when multiprocessor bit is clear
// - Tx done set by hardware, software clears
// - Rx done set by hardware, software clears
// - Timer1 reload byte sets variable rate
// - Dedicated reload value sets variable rate
// - Reload value is ten bits, two registers
// - Stop mode halts the serial port
// - Timer1 low byte reloads from high byte
module serial_port_uart_baudgen #(
  parameter int FIFO_DEPTH = 2,
  parameter int FIFO_WIDTH = 8
) (
  input wire logic clk_i, // 20 MHz peripheral clock
  input wire logic rst_n_i, // Async reset, active low
  input wire uart_pkg::sfr_req_type sfr_i, // CPU register access
  output logic [7:0] sfr_rdata_o, // Register read data
  input wire logic [7:0] timer1_reload_byte_i, // Timer1 high byte
  input wire logic stop_mode_i, // Chip is in stop mode
  input wire logic rxd_i, // Data pin level
  output logic rxd_o, // Data pin drive in shift mode
  output logic rxd_oe_o, // Data pin drive enable
  output logic txd_o, // Serial out or shift clock
  output logic serial_irq_o // Serial port request
);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int NW = uart_pkg::PERIOD_W;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] t);
    return a == t;
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(FIFO_DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  logic [7:0] misc_control, serial_control, baud_reload_low;
  logic [7:0] baud_reload_high, periph_freq_control;
  logic wr_misc, wr_serial_control, wr_serial_data_buffer, wr_rell, wr_relh, wr_pf, rd_serial_data_buffer;
  logic run, baud_doubler, baud_source_select, rx_en, multiproc_enable;
  logic [1:0] reload_prescale_sel, timer1_prescale_sel;
  logic [9:0] baud_reload_value;
  uart_pkg::uart_mode_type uart_mode;
  logic nine_bit;
  logic [8:0] t1_span;
  logic [10:0] reload_span;
  logic [NW-1:0] t1_div, t1_period, reload_period, next_period;
  logic [NW-1:0] bit_period, half_period;
  uart_pkg::tx_state_type tx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_bits;
  logic [NW-1:0] tx_timer;
  logic [7:0] tx_hold;
  logic tx_pend, tx_load, tx_tick, ti_set;
  logic [2:0] rxd_sync;
  logic rxd_clean, rx_last;
  uart_pkg::rx_state_type rx_state;
  logic [9:0] rx_shift, rx_fin;
  logic [3:0] rx_bits;
  logic [NW-1:0] rx_timer;
  logic rx_tick, rx_ready, rx_done, rx_accept, rx_ninth, rx_stop;
  logic [7:0] rx_byte;
  logic [FIFO_WIDTH-1:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [CW-1:0] fifo_count;
  logic fifo_pop;
  logic next_txd, next_rxd, next_rxd_oe;

  //////////////////////////////////////////////////////////////////////
  // Register access decode

  assign wr_misc = sfr_i.wr && sfr_hit(sfr_i.addr, uart_pkg::MISC_CONTROL_ADDR);
  assign wr_serial_control = sfr_i.wr && sfr_hit(sfr_i.addr, uart_pkg::SERIAL_CONTROL_ADDR);
  assign wr_serial_data_buffer = sfr_i.wr && sfr_hit(sfr_i.addr, uart_pkg::SERIAL_DATA_BUFFER_ADDR);
  assign wr_rell = sfr_i.wr && sfr_hit(sfr_i.addr, uart_pkg::BAUD_RELOAD_LOW_ADDR);
  assign wr_relh = sfr_i.wr && sfr_hit(sfr_i.addr, uart_pkg::BAUD_RELOAD_HIGH_ADDR);
  assign wr_pf = sfr_i.wr && sfr_hit(sfr_i.addr, uart_pkg::PERIPH_FREQ_CONTROL_ADDR);
  assign rd_serial_data_buffer = sfr_i.rd && sfr_hit(sfr_i.addr, uart_pkg::SERIAL_DATA_BUFFER_ADDR);

  assign run = !stop_mode_i;
  assign uart_mode = uart_pkg::uart_mode_type'(serial_control[7:6]);
  assign nine_bit = serial_control[7];
  assign multiproc_enable = serial_control[uart_pkg::SC_MULTIPROC];
  assign rx_en = serial_control[uart_pkg::SC_RX_EN];
  assign baud_doubler = misc_control[uart_pkg::MC_BAUD_DOUBLER];
  assign baud_source_select = misc_control[uart_pkg::MC_BAUD_SOURCE];
  assign reload_prescale_sel = periph_freq_control[uart_pkg::PF_RELOAD_PS_LSB +: 2];
  assign timer1_prescale_sel = periph_freq_control[uart_pkg::PF_T1_PS_LSB +: 2];
  assign baud_reload_value = {baud_reload_high[1:0], baud_reload_low};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      misc_control <= uart_pkg::MISC_CONTROL_RESET;
      baud_reload_low <= uart_pkg::BAUD_RELOAD_LOW_RESET;
      baud_reload_high <= uart_pkg::BAUD_RELOAD_HIGH_RESET;
      periph_freq_control <= uart_pkg::PERIPH_FREQ_CONTROL_RESET;
    end else begin
      if (wr_misc) begin
        misc_control <= (misc_control & ~uart_pkg::MISC_CONTROL_WMASK) |
                        (sfr_i.wdata & uart_pkg::MISC_CONTROL_WMASK);
      end
      if (wr_rell) begin
        baud_reload_low <= sfr_i.wdata;
      end
      if (wr_relh) begin
        baud_reload_high <= sfr_i.wdata & uart_pkg::BAUD_RELOAD_HIGH_WMASK;
      end
      if (wr_pf) begin
        periph_freq_control <= sfr_i.wdata & uart_pkg::PERIPH_FREQ_CONTROL_WMASK;
      end
    end
  end

  // Flags: a hardware set in the same cycle as a software write wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_control <= uart_pkg::SERIAL_CONTROL_RESET;
    end else begin
      if (wr_serial_control) begin
        serial_control <= sfr_i.wdata;
      end
      if (rx_accept && nine_bit) begin
        serial_control[uart_pkg::SC_RX_NINTH] <= rx_ninth;
      end else if (rx_accept && uart_mode == uart_pkg::MODE_UART8 && !multiproc_enable) begin
        serial_control[uart_pkg::SC_RX_NINTH] <= rx_stop;
      end
      serial_control[uart_pkg::SC_TX_DONE] <= ti_set | (wr_serial_control ?
        sfr_i.wdata[uart_pkg::SC_TX_DONE] : serial_control[uart_pkg::SC_TX_DONE]);
      serial_control[uart_pkg::SC_RX_DONE] <= rx_accept | (wr_serial_control ?
        sfr_i.wdata[uart_pkg::SC_RX_DONE] : serial_control[uart_pkg::SC_RX_DONE]);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bit period; Timer1 reload counting folded into one span

  always_comb begin
    t1_span = uart_pkg::T1_SPAN - {1'b0, timer1_reload_byte_i};
    reload_span = uart_pkg::RELOAD_SPAN - {1'b0, baud_reload_value};
    unique case (timer1_prescale_sel)
      2'b01: t1_div = uart_pkg::T1_DIV_1;
      2'b10: t1_div = uart_pkg::T1_DIV_96;
      default: t1_div = uart_pkg::SHIFT_DIV;
    endcase
    t1_period = (NW'(t1_span) * t1_div) <<
                (uart_pkg::T1_FRAME_SHIFT - int'(baud_doubler));
    reload_period = NW'(reload_span) << (uart_pkg::RELOAD_BASE_SHIFT -
                    int'(reload_prescale_sel) - int'(baud_doubler));
    unique case (uart_mode)
      uart_pkg::MODE_SHIFT: next_period = uart_pkg::SHIFT_DIV;
      uart_pkg::MODE_UART9_FIXED: next_period = baud_doubler ?
        uart_pkg::FIXED_DIV_FAST : uart_pkg::FIXED_DIV_SLOW;
      uart_pkg::MODE_UART8,
      uart_pkg::MODE_UART9_VAR: next_period = baud_source_select ?
        reload_period : t1_period;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_period <= uart_pkg::SHIFT_DIV;
    end else begin
      bit_period <= next_period;
    end
  end
  assign half_period = bit_period >> 1;

  //////////////////////////////////////////////////////////////////////
  // Transmitter

  assign tx_load = run && (tx_state == uart_pkg::TX_IDLE) && tx_pend;
  assign tx_tick = tx_timer == '0;
  assign ti_set = run && (tx_state == uart_pkg::TX_SHIFT) && tx_tick &&
                  (tx_bits == ((uart_mode == uart_pkg::MODE_SHIFT) ? 4'h1 : 4'h2));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_hold <= uart_pkg::RX_DATA_RESET;
      tx_pend <= 1'b0;
    end else if (wr_serial_data_buffer) begin
      tx_hold <= sfr_i.wdata;
      tx_pend <= 1'b1;
    end else if (tx_load) begin
      tx_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state <= uart_pkg::TX_IDLE;
      tx_shift <= '1;
      tx_bits <= '0;
      tx_timer <= '0;
    end else if (tx_load) begin
      tx_state <= uart_pkg::TX_SHIFT;
      tx_timer <= NW'(bit_period - 1'b1);
      unique case (uart_mode)
        uart_pkg::MODE_SHIFT: begin
          tx_shift <= {3'b111, tx_hold};
          tx_bits <= uart_pkg::SHIFT_BITS;
        end
        uart_pkg::MODE_UART8: begin
          tx_shift <= {2'b11, tx_hold, 1'b0};
          tx_bits <= uart_pkg::UART8_BITS;
        end
        uart_pkg::MODE_UART9_FIXED,
        uart_pkg::MODE_UART9_VAR: begin
          tx_shift <= {1'b1, serial_control[uart_pkg::SC_TX_NINTH], tx_hold, 1'b0};
          tx_bits <= uart_pkg::UART9_BITS;
        end
      endcase
    end else if (run && tx_state == uart_pkg::TX_SHIFT) begin
      if (tx_tick) begin
        tx_timer <= NW'(bit_period - 1'b1);
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_bits <= tx_bits - 4'h1;
        if (tx_bits == 4'h1) begin
          tx_state <= uart_pkg::TX_IDLE;
        end
      end else begin
        tx_timer <= tx_timer - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Receiver

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxd_sync <= 3'b111;
      rxd_clean <= 1'b1;
      rx_last <= 1'b1;
    end else begin
      rxd_sync <= {rxd_sync[1:0], rxd_i};
      if (rxd_sync[1] == rxd_sync[2]) begin
        rxd_clean <= rxd_sync[2];
      end
      rx_last <= rxd_clean;
    end
  end

  assign rx_ready = fifo_count < CW'(FIFO_DEPTH);
  assign rx_tick = rx_timer == '0;
  assign rx_done = run && rx_en && (rx_state == uart_pkg::RX_DATA) && rx_tick &&
                   (rx_bits == 4'h1);
  assign rx_fin = {rxd_clean, rx_shift[9:1]};
  assign rx_byte = (uart_mode == uart_pkg::MODE_SHIFT) ? rx_fin[9:2] :
                   nine_bit ? rx_fin[7:0] : rx_fin[8:1];
  assign rx_ninth = rx_fin[8];
  assign rx_stop = rx_fin[9];
  assign rx_accept = rx_done && !(nine_bit && multiproc_enable && !rx_ninth);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state <= uart_pkg::RX_IDLE;
      rx_shift <= '0;
      rx_bits <= '0;
      rx_timer <= '0;
    end else if (run) begin
      unique case (rx_state)
        uart_pkg::RX_IDLE: begin
          if (uart_mode == uart_pkg::MODE_SHIFT) begin
            if (rx_en && rx_ready && !serial_control[uart_pkg::SC_RX_DONE] &&
                tx_state == uart_pkg::TX_IDLE && !tx_pend) begin
              rx_state <= uart_pkg::RX_DATA;
              rx_timer <= NW'(bit_period - 1'b1);
              rx_bits <= uart_pkg::SHIFT_BITS;
            end
          end else if (rx_en && rx_ready && rx_last && !rxd_clean) begin
            rx_state <= uart_pkg::RX_START;
            rx_timer <= NW'(half_period - 1'b1);
            rx_bits <= (nine_bit ? uart_pkg::UART9_BITS : uart_pkg::UART8_BITS) - 4'h1;
          end
        end
        uart_pkg::RX_START: begin
          if (!rx_en || (rx_tick && rxd_clean)) begin
            rx_state <= uart_pkg::RX_IDLE;
          end else if (rx_tick) begin
            rx_state <= uart_pkg::RX_DATA;
            rx_timer <= NW'(bit_period - 1'b1);
          end else begin
            rx_timer <= rx_timer - 1'b1;
          end
        end
        uart_pkg::RX_DATA: begin
          if (!rx_en) begin
            rx_state <= uart_pkg::RX_IDLE;
          end else if (rx_tick) begin
            rx_shift <= rx_fin;
            rx_bits <= rx_bits - 4'h1;
            rx_timer <= NW'(bit_period - 1'b1);
            if (rx_bits == 4'h1) begin
              rx_state <= uart_pkg::RX_IDLE;
            end
          end else begin
            rx_timer <= rx_timer - 1'b1;
          end
        end
        default: rx_state <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Two-entry receive buffer drained by data register reads

  assign fifo_pop = rd_serial_data_buffer && (fifo_count != '0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_count <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_mem[i] <= '0;
      end
    end else begin
      if (rx_accept) begin
        fifo_mem[wr_ptr] <= FIFO_WIDTH'(rx_byte);
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (fifo_pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      fifo_count <= CW'(fifo_count + CW'(rx_accept) - CW'(fifo_pop));
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read data and pins

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= '0;
    end else if (sfr_i.rd) begin
      unique case (sfr_i.addr)
        uart_pkg::MISC_CONTROL_ADDR: sfr_rdata_o <= misc_control;
        uart_pkg::SERIAL_CONTROL_ADDR: sfr_rdata_o <= serial_control;
        uart_pkg::SERIAL_DATA_BUFFER_ADDR: sfr_rdata_o <= 8'(fifo_mem[rd_ptr]);
        uart_pkg::BAUD_RELOAD_LOW_ADDR: sfr_rdata_o <= baud_reload_low;
        uart_pkg::BAUD_RELOAD_HIGH_ADDR: sfr_rdata_o <= baud_reload_high;
        uart_pkg::PERIPH_FREQ_CONTROL_ADDR: sfr_rdata_o <= periph_freq_control;
        default: sfr_rdata_o <= '0;
      endcase
    end
  end

  always_comb begin
    next_rxd_oe = (uart_mode == uart_pkg::MODE_SHIFT) && (tx_state == uart_pkg::TX_SHIFT);
    next_rxd = next_rxd_oe ? tx_shift[0] : 1'b1;
    if (uart_mode == uart_pkg::MODE_SHIFT) begin
      // Shift clock low in the first half of each bit, rising mid-bit
      if (tx_state == uart_pkg::TX_SHIFT) begin
        next_txd = tx_timer < half_period;
      end else if (rx_state == uart_pkg::RX_DATA) begin
        next_txd = rx_timer < half_period;
      end else begin
        next_txd = 1'b1;
      end
    end else begin
      next_txd = (tx_state == uart_pkg::TX_SHIFT) ? tx_shift[0] : 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txd_o <= 1'b1;
      rxd_o <= 1'b1;
      rxd_oe_o <= 1'b0;
      serial_irq_o <= 1'b0;
    end else begin
      txd_o <= next_txd;
      rxd_o <= next_rxd;
      rxd_oe_o <= next_rxd_oe;
      serial_irq_o <= serial_control[uart_pkg::SC_TX_DONE] |
                      serial_control[uart_pkg::SC_RX_DONE];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  a_write_starts_tx: assert property (
    wr_serial_data_buffer && run && tx_state == uart_pkg::TX_IDLE && !tx_pend && !stop_mode_i
    |=> tx_pend ##1 tx_state == uart_pkg::TX_SHIFT)
    else $error("data write did not start a frame");
  a_read_pops_buffer: assert property (
    fifo_pop && !rx_accept |=> fifo_count == $past(fifo_count) - 1'b1)
    else $error("read did not drain receive buffer");
  a_shift_mode_rate: assert property (
    (uart_mode == uart_pkg::MODE_SHIFT)[*2] |-> bit_period == uart_pkg::SHIFT_DIV)
    else $error("shift mode period wrong");
  a_fixed_mode_rate: assert property (
    (uart_mode == uart_pkg::MODE_UART9_FIXED && $stable(baud_doubler))[*2]
    |-> bit_period == (baud_doubler ? uart_pkg::FIXED_DIV_FAST : uart_pkg::FIXED_DIV_SLOW))
    else $error("fixed mode period wrong");
  a_rx_disabled_idle: assert property (
    !rx_en && rx_state == uart_pkg::RX_IDLE |=> rx_state == uart_pkg::RX_IDLE)
    else $error("receiver started while disabled");
  a_tx_ninth_sent: assert property (
    tx_load && nine_bit |=> tx_shift[9] == $past(serial_control[uart_pkg::SC_TX_NINTH]))
    else $error("ninth bit not loaded");
  a_rx_ninth_kept: assert property (
    rx_accept && nine_bit && !wr_serial_control
    |=> serial_control[uart_pkg::SC_RX_NINTH] == $past(rx_ninth))
    else $error("received ninth bit not stored");
  a_tx_done_set: assert property (
    ti_set |=> serial_control[uart_pkg::SC_TX_DONE] ##1 serial_irq_o)
    else $error("tx done flag or request missing");
  a_rx_done_set: assert property (
    rx_accept |=> serial_control[uart_pkg::SC_RX_DONE] && fifo_count != '0)
    else $error("rx done flag missing");
  a_stop_halts_tx: assert property (
    stop_mode_i && tx_state == uart_pkg::TX_SHIFT |=> $stable(tx_timer) && $stable(tx_shift))
    else $error("transmitter ran in stop mode");
  a_mp_drops_frame: assert property (
    rx_done && nine_bit && multiproc_enable && !rx_ninth && fifo_count == '0 && !fifo_pop
    |=> fifo_count == '0)
    else $error("multiprocessor frame not dropped");

  c_uart8_rx: cover property (rx_accept && uart_mode == uart_pkg::MODE_UART8);
  c_shift_tx: cover property (ti_set && uart_mode == uart_pkg::MODE_SHIFT);
  c_buffer_full: cover property (fifo_count == CW'(FIFO_DEPTH));
  c_mp_reject: cover property (rx_done && !rx_accept);
endmodule

// File: uart_pkg.sv
package uart_pkg;
  // Special function register addresses
  localparam logic [7:0] MISC_CONTROL_ADDR = 8'h8e;
  localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;
  localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR = 8'h99;
  localparam logic [7:0] BAUD_RELOAD_LOW_ADDR = 8'h9a;
  localparam logic [7:0] BAUD_RELOAD_HIGH_ADDR = 8'h9b;
  localparam logic [7:0] PERIPH_FREQ_CONTROL_ADDR = 8'hd1;
  // Reset values and writable bits
  localparam logic [7:0] MISC_CONTROL_RESET = 8'h11;
  localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RX_DATA_RESET = 8'h00;
  localparam logic [7:0] BAUD_RELOAD_LOW_RESET = 8'h00;
  localparam logic [7:0] BAUD_RELOAD_HIGH_RESET = 8'h00;
  localparam logic [7:0] PERIPH_FREQ_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MISC_CONTROL_WMASK = 8'h9e;
  localparam logic [7:0] BAUD_RELOAD_HIGH_WMASK = 8'h03;
  localparam logic [7:0] PERIPH_FREQ_CONTROL_WMASK = 8'h3f;
  // Field positions
  localparam int SC_MULTIPROC = 5;
  localparam int SC_RX_EN = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;
  localparam int MC_BAUD_DOUBLER = 3;
  localparam int MC_BAUD_SOURCE = 2;
  localparam int PF_RELOAD_PS_LSB = 4;
  localparam int PF_T1_PS_LSB = 2;
  // Bit period arithmetic, in peripheral clock cycles
  localparam int PERIOD_W = 20;
  localparam logic [19:0] SHIFT_DIV = 20'h0_000c;
  localparam logic [19:0] FIXED_DIV_SLOW = 20'h0_0040;
  localparam logic [19:0] FIXED_DIV_FAST = 20'h0_0020;
  localparam logic [19:0] T1_DIV_1 = 20'h0_0001;
  localparam logic [19:0] T1_DIV_96 = 20'h0_0060;
  localparam int T1_FRAME_SHIFT = 5;
  localparam int RELOAD_BASE_SHIFT = 6;
  localparam logic [8:0] T1_SPAN = 9'h100;
  localparam logic [10:0] RELOAD_SPAN = 11'h400;
  // Bits per frame
  localparam logic [3:0] SHIFT_BITS = 4'h8;
  localparam logic [3:0] UART8_BITS = 4'ha;
  localparam logic [3:0] UART9_BITS = 4'hb;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_UART9_FIXED = 2'b10,
    MODE_UART9_VAR = 2'b11
  } uart_mode_type;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10
  } rx_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_type;
endpackage

// File: remote_serial.sv
`timescale 1ns/1ps
module remote_serial (
  input wire logic clk_i, // Bench clock
  input wire logic txd_i, // Line from the device
  input wire logic [15:0] period_i, // Bit time in cycles
  input wire logic nine_i, // Frames carry a ninth bit
  output logic line_o, // Line to the device, idles high
  output logic [8:0] word_o, // Last frame heard
  output logic word_stb_o // Pulses when a frame is heard
);
  initial begin
    line_o = 1'b1;
    word_o = '0;
    word_stb_o = 1'b0;
  end
  // Samples at bit centres; in 8-bit frames the ninth is the stop bit
  always begin
    @(negedge txd_i);
    repeat (period_i / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (period_i) @(posedge clk_i);
      word_o[i] = txd_i;
    end
    word_stb_o = 1'b1;
    @(posedge clk_i);
    word_stb_o = 1'b0;
  end
  task automatic send(input logic [8:0] d);
    logic [10:0] f;
    f = nine_i ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= f[i];
      repeat (period_i) @(posedge clk_i);
    end
  endtask
endmodule

// File: test_serial_port_uart_baudgen.sv
`timescale 1ns/1ps
module test_serial_port_uart_baudgen;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  uart_pkg::sfr_req_type sfr = '0;
  logic [7:0] sfr_rdata_o;
  logic rxd_o, rxd_oe_o, txd_o, serial_irq_o, far_line, word_stb, nine = 1'b1, rd_seen = 1'b0;
  logic stop = 1'b0, shift_mode = 1'b0;
  logic [7:0] th1 = 8'h00, sh = 8'h00;
  logic [3:0] rises = 4'h0;
  logic [8:0] word;
  logic [15:0] per = 16'h0040;
  logic [15:0] lfsr = 16'h5b5d;
  logic [7:0] b0, b1, b2;
  logic [7:0] rd_q[$];
  logic [8:0] tx_q[$];
  int error_cnt = 0;
  int compares = 0;
  wire pin = rxd_oe_o ? rxd_o : far_line;
  always #25 clk_i = ~clk_i;
  serial_port_uart_baudgen dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_i(sfr),
    .sfr_rdata_o(sfr_rdata_o), .timer1_reload_byte_i(th1), .stop_mode_i(stop),
    .rxd_i(pin), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o),
    .serial_irq_o(serial_irq_o));
  remote_serial far (.clk_i(clk_i), .txd_i(txd_o), .period_i(per), .nine_i(nine),
    .line_o(far_line), .word_o(word), .word_stb_o(word_stb));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic check9(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t line word %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_i);
    sfr.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    @(posedge clk_i);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_i);
    sfr.rd <= 1'b0;
  endtask
  task automatic conclude();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Read data is settled one edge after the device takes the read
  always @(posedge clk_i) begin
    if (rd_seen) check8(sfr_rdata_o, rd_q.pop_front());
    rd_seen <= sfr.rd;
  end
  always @(posedge word_stb) begin
    if (!shift_mode) check9(word, tx_q.pop_front());
  end
  // Shift clock rises mid-bit, while the data pin is steady
  always @(posedge txd_o) begin
    if (shift_mode && rxd_oe_o) begin
      sh <= {rxd_o, sh[7:1]};
      rises <= rises + 4'h1;
    end
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'h8e, 8'h11);
    rd(8'h98, 8'h00);
    rd(8'h99, 8'h00);
    rd(8'h9a, 8'h00);
    rd(8'h9b, 8'h00);
    rd(8'hd1, 8'h00);
    rd(8'h9c, 8'h00);
    $display("test reset_values done");
    // Fixed rate 9-bit mode, both directions at once
    lfsr = step(lfsr);
    b0 = lfsr[7:0];
    lfsr = step(lfsr);
    b1 = lfsr[7:0];
    wr(8'h98, 8'h98);
    tx_q.push_back({1'b1, b0});
    fork
      wr(8'h99, b0);
      far.send({1'b1, b1});
    join
    repeat (8) @(posedge clk_i);
    check8({7'h00, serial_irq_o}, 8'h01);
    rd(8'h98, 8'h9f);
    rd(8'h99, b1);
    $display("test fixed_rate_duplex done");
    // Dedicated reload value, 16-cycle bits, two frames held
    wr(8'h8e, 8'h04);
    wr(8'hd1, 8'hff);
    wr(8'h9a, 8'hfe);
    wr(8'h9b, 8'hff);
    rd(8'h8e, 8'h05);
    rd(8'hd1, 8'h3f);
    rd(8'h9b, 8'h03);
    per <= 16'h0010;
    nine <= 1'b0;
    wr(8'h98, 8'h50);
    lfsr = step(lfsr);
    b0 = lfsr[7:0];
    lfsr = step(lfsr);
    b1 = lfsr[7:0];
    lfsr = step(lfsr);
    b2 = lfsr[7:0];
    far.send({1'b1, b0});
    far.send({1'b1, b1});
    repeat (8) @(posedge clk_i);
    rd(8'h99, b0);
    rd(8'h99, b1);
    rd(8'h98, 8'h55);
    tx_q.push_back({1'b1, b2});
    wr(8'h99, b2);
    repeat (40) @(posedge clk_i);
    // A short freeze mid-frame stays inside the partner's sampling margin
    stop <= 1'b1;
    repeat (3) @(posedge clk_i);
    stop <= 1'b0;
    repeat (160) @(posedge clk_i);
    rd(8'h98, 8'h57);
    $display("test reload_rate_buffer done");
    // Receiver disabled ignores the line
    wr(8'h98, 8'h40);
    far.send({1'b1, 8'h5a});
    repeat (8) @(posedge clk_i);
    rd(8'h98, 8'h40);
    repeat (4) @(posedge clk_i);
    check8({7'h00, serial_irq_o}, 8'h00);
    check8(8'(tx_q.size()), 8'h00);
    $display("test receive_disabled done");
    // Timer1 rate in 9-bit variable mode, address filter on
    wr(8'h8e, 8'h08);
    wr(8'hd1, 8'h04);
    th1 <= 8'hff;
    nine <= 1'b1;
    wr(8'h98, 8'hf0);
    lfsr = step(lfsr);
    b0 = lfsr[7:0];
    lfsr = step(lfsr);
    b1 = lfsr[7:0];
    far.send({1'b0, b0});
    repeat (8) @(posedge clk_i);
    rd(8'h98, 8'hf0);
    far.send({1'b1, b1});
    repeat (8) @(posedge clk_i);
    rd(8'h98, 8'hf5);
    rd(8'h99, b1);
    $display("test timer1_multiproc done");
    // Shift register mode: data on the data pin, clock on the other
    shift_mode <= 1'b1;
    wr(8'h98, 8'h00);
    lfsr = step(lfsr);
    b2 = lfsr[7:0];
    wr(8'h99, b2);
    repeat (110) @(posedge clk_i);
    check8(sh, b2);
    check8({4'h0, rises}, 8'h08);
    rd(8'h98, 8'h02);
    $display("test shift_register done");
    conclude();
  end
endmodule
